//--- src/thcmd_pkg.sv
// thcmd_pkg: opcodes, widths, field positions and reset values for the
// three-wire command decoder of the thermometer.
// assumes a 10 MHz system clock sampling the serial pins.
package thcmd_pkg;

  // opcodes
  localparam logic [7:0] THCMD_OP_RD_TEMP   = 8'hAA;
  localparam logic [7:0] THCMD_OP_RD_COUNT  = 8'hA0;
  localparam logic [7:0] THCMD_OP_RD_SLOPE  = 8'hA9;
  localparam logic [7:0] THCMD_OP_START     = 8'hEE;
  localparam logic [7:0] THCMD_OP_STOP      = 8'h22;
  localparam logic [7:0] THCMD_OP_WR_HIGH   = 8'h01;
  localparam logic [7:0] THCMD_OP_WR_LOW    = 8'h02;
  localparam logic [7:0] THCMD_OP_RD_HIGH   = 8'hA1;
  localparam logic [7:0] THCMD_OP_RD_LOW    = 8'hA2;
  localparam logic [7:0] THCMD_OP_WR_CONFIG = 8'h0C;
  localparam logic [7:0] THCMD_OP_RD_CONFIG = 8'hAC;

  // transfer lengths
  localparam int unsigned THCMD_OP_BITS   = 8;
  localparam int unsigned THCMD_WORD_BITS = 9;
  localparam int unsigned THCMD_CFG_BITS  = 8;
  localparam logic [3:0]  THCMD_OP_LEN    = 4'h8;
  localparam logic [3:0]  THCMD_WORD_LEN  = 4'h9;
  localparam logic [3:0]  THCMD_CFG_LEN   = 4'h8;

  // configuration field positions
  localparam int unsigned THCMD_CFG_ONESHOT = 0;
  localparam int unsigned THCMD_CFG_CPU     = 1;
  localparam int unsigned THCMD_CFG_NVB     = 4;
  localparam int unsigned THCMD_CFG_LOWF    = 5;
  localparam int unsigned THCMD_CFG_HIGHF   = 6;
  localparam int unsigned THCMD_CFG_DONE    = 7;

  // reset values
  localparam logic [7:0] THCMD_CFG_RST   = 8'h88;
  localparam logic [7:0] THCMD_CFG_FIXED = 8'h08;
  localparam logic [7:0] THCMD_CFG_WMASK = 8'h63;
  localparam logic [8:0] THCMD_HIGH_RST  = 9'h000;
  localparam logic [8:0] THCMD_LOW_RST   = 9'h000;

  // nonvolatile write busy time
  localparam int unsigned THCMD_CLK_HZ    = 10_000_000;
  localparam int unsigned THCMD_NV_MS     = 10;
  localparam int unsigned THCMD_NV_CYCLES =
    THCMD_NV_MS * (THCMD_CLK_HZ / 1000);

  typedef enum logic [3:0] {
    THCMD_ST_IDLE = 4'b0001,
    THCMD_ST_OPC  = 4'b0010,
    THCMD_ST_DATA = 4'b0100,
    THCMD_ST_HOLD = 4'b1000
  } thcmd_state_t;

endpackage : thcmd_pkg

//--- src/thcmd_sync.sv
// thcmd_sync: two-flop synchroniser bank for the serial pins.
// assumes inputs are asynchronous to clk_in.
`timescale 1ns/10ps
module thcmd_sync #(
  parameter int unsigned WIDTH = 3
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // pins
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          meta_r[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_r[i]   <= async_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule : thcmd_sync

//--- src/thcmd_top.sv
// thcmd_top: command decoder behind the three-wire serial port.
// assumes the host drives serial clock and reset line; the conversion
// engine supplies temperature, counter and slope and takes start/stop.
`timescale 1ns/10ps
module thcmd_top
  import thcmd_pkg::*;
#(
  parameter int unsigned NV_CYCLES = THCMD_NV_CYCLES
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // three-wire pins
  input  wire logic       ser_clk_in,
  input  wire logic       ser_rst_in,
  input  wire logic       dq_in,
  output logic            dq_out,
  output logic            dq_oe_out,
  // conversion engine side
  input  wire logic [8:0] temp_in,
  input  wire logic [8:0] count_in,
  input  wire logic [8:0] slope_in,
  input  wire logic       conv_done_in,
  input  wire logic       high_flag_set_in,
  input  wire logic       low_flag_set_in,
  output logic            conv_start_out,
  output logic            conv_stop_out,
  output logic            conv_oneshot_out,
  output logic            conv_cpu_out,
  output logic [8:0]      high_temp_limit_out,
  output logic [8:0]      low_temp_limit_out
);

  logic [2:0]   pins_s;
  logic         sclk_s;
  logic         srst_s;
  logic         dq_s;
  logic         sclk_d_r;
  logic         rise;
  logic         fall;
  thcmd_state_t state_r;
  logic [7:0]   opc_r;
  logic [3:0]   cnt_r;
  logic [3:0]   len_r;
  logic         rd_r;
  logic [8:0]   sh_r;
  logic [7:0]   cfg_r;
  logic [7:0]   cfg_view;
  logic [8:0]   high_r;
  logic [8:0]   low_r;
  logic [31:0]  nv_cnt_r;
  logic         nv_busy;
  logic [7:0]   opc_full;
  logic         opc_last;
  logic         data_last;
  logic [8:0]   wr_word;
  logic         wr_high;
  logic         wr_low;
  logic         wr_cfg;

  thcmd_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({dq_in, ser_rst_in, ser_clk_in}),
    .sync_out (pins_s)
  );

  assign sclk_s = pins_s[0];
  assign srst_s = pins_s[1];
  assign dq_s   = pins_s[2];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  assign rise = sclk_s & ~sclk_d_r;
  assign fall = ~sclk_s & sclk_d_r;

  assign opc_full  = {dq_s, opc_r[7:1]};
  assign opc_last  = (state_r == THCMD_ST_OPC) && rise &&
                     (cnt_r == THCMD_OP_LEN - 4'h1);
  assign data_last = (state_r == THCMD_ST_DATA) && rise && !rd_r &&
                     (cnt_r == len_r - 4'h1);
  assign wr_word   = {dq_s, sh_r[8:1]};
  assign nv_busy   = (nv_cnt_r != 32'h0000_0000);

  assign wr_high = data_last && (opc_r == THCMD_OP_WR_HIGH);
  assign wr_low  = data_last && (opc_r == THCMD_OP_WR_LOW);
  assign wr_cfg  = data_last && (opc_r == THCMD_OP_WR_CONFIG);

  assign cfg_view = (cfg_r & ~(8'h01 << THCMD_CFG_NVB)) |
                    ({7'h00, nv_busy} << THCMD_CFG_NVB);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= THCMD_ST_IDLE;
      opc_r   <= 8'h00;
      cnt_r   <= 4'h0;
      len_r   <= 4'h0;
      rd_r    <= 1'b0;
      sh_r    <= 9'h000;
    end else if (!srst_s) begin
      state_r <= THCMD_ST_IDLE;
      cnt_r   <= 4'h0;
    end else begin
      unique case (state_r)
        THCMD_ST_IDLE: begin
          state_r <= THCMD_ST_OPC;
          cnt_r   <= 4'h0;
        end
        THCMD_ST_OPC: begin
          if (rise) begin
            opc_r <= opc_full;
            cnt_r <= cnt_r + 4'h1;
          end
          if (opc_last) begin
            cnt_r   <= 4'h0;
            state_r <= THCMD_ST_DATA;
            unique case (opc_full)
              THCMD_OP_RD_TEMP: begin
                rd_r <= 1'b1; len_r <= THCMD_WORD_LEN; sh_r <= temp_in;
              end
              THCMD_OP_RD_COUNT: begin
                rd_r <= 1'b1; len_r <= THCMD_WORD_LEN; sh_r <= count_in;
              end
              THCMD_OP_RD_SLOPE: begin
                rd_r <= 1'b1; len_r <= THCMD_WORD_LEN; sh_r <= slope_in;
              end
              THCMD_OP_RD_HIGH: begin
                rd_r <= 1'b1; len_r <= THCMD_WORD_LEN; sh_r <= high_r;
              end
              THCMD_OP_RD_LOW: begin
                rd_r <= 1'b1; len_r <= THCMD_WORD_LEN; sh_r <= low_r;
              end
              THCMD_OP_RD_CONFIG: begin
                rd_r <= 1'b1; len_r <= THCMD_CFG_LEN;
                sh_r <= {1'b0, cfg_view};
              end
              THCMD_OP_WR_HIGH, THCMD_OP_WR_LOW: begin
                rd_r <= 1'b0; len_r <= THCMD_WORD_LEN; sh_r <= 9'h000;
              end
              THCMD_OP_WR_CONFIG: begin
                rd_r <= 1'b0; len_r <= THCMD_CFG_LEN; sh_r <= 9'h000;
              end
              default: begin
                // no data phase, line stays released
                rd_r    <= 1'b0;
                len_r   <= 4'h0;
                state_r <= THCMD_ST_HOLD;
              end
            endcase
          end
        end
        THCMD_ST_DATA: begin
          if (rise) begin
            cnt_r <= cnt_r + 4'h1;
            if (rd_r) begin
              // next bit toward the LSB position
              sh_r <= {1'b0, sh_r[8:1]};
            end else begin
              sh_r <= wr_word;
            end
            if (cnt_r == len_r - 4'h1) begin
              state_r <= THCMD_ST_HOLD;
            end
          end
        end
        THCMD_ST_HOLD: begin
          state_r <= THCMD_ST_HOLD;
        end
      endcase
    end
  end

  // launch on fall, release on rise or reset line low
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dq_out    <= 1'b0;
      dq_oe_out <= 1'b0;
    end else if (!srst_s || rise ||
                 (state_r != THCMD_ST_DATA) || !rd_r) begin
      dq_oe_out <= 1'b0;
    end else if (fall) begin
      dq_out    <= sh_r[0];
      dq_oe_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      high_r <= THCMD_HIGH_RST;
      low_r  <= THCMD_LOW_RST;
    end else begin
      if (wr_high) begin
        high_r <= wr_word;
      end
      if (wr_low) begin
        low_r <= wr_word;
      end
    end
  end

  // configuration, hardware flag sets win over a written zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_r <= THCMD_CFG_RST;
    end else begin
      // an 8-bit word ends one place up in the 9-bit shifter
      if (wr_cfg) begin
        cfg_r <= (wr_word[8:1] & THCMD_CFG_WMASK) | THCMD_CFG_FIXED |
                 (cfg_r & ~THCMD_CFG_WMASK & ~THCMD_CFG_FIXED);
      end
      cfg_r[THCMD_CFG_DONE] <= conv_done_in;
      if (high_flag_set_in) begin
        cfg_r[THCMD_CFG_HIGHF] <= 1'b1;
      end
      if (low_flag_set_in) begin
        cfg_r[THCMD_CFG_LOWF] <= 1'b1;
      end
    end
  end

  // nonvolatile busy timer, restarted by each stored write
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nv_cnt_r <= 32'h0000_0000;
    end else if (wr_high || wr_low || wr_cfg) begin
      nv_cnt_r <= NV_CYCLES;
    end else if (nv_busy) begin
      nv_cnt_r <= nv_cnt_r - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_start_out <= 1'b0;
      conv_stop_out  <= 1'b0;
    end else begin
      conv_start_out <= opc_last && (opc_full == THCMD_OP_START);
      conv_stop_out  <= opc_last && (opc_full == THCMD_OP_STOP);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_oneshot_out    <= THCMD_CFG_RST[THCMD_CFG_ONESHOT];
      conv_cpu_out        <= THCMD_CFG_RST[THCMD_CFG_CPU];
      high_temp_limit_out <= THCMD_HIGH_RST;
      low_temp_limit_out  <= THCMD_LOW_RST;
    end else begin
      conv_oneshot_out    <= cfg_r[THCMD_CFG_ONESHOT];
      conv_cpu_out        <= cfg_r[THCMD_CFG_CPU];
      high_temp_limit_out <= high_r;
      low_temp_limit_out  <= low_r;
    end
  end

endmodule : thcmd_top

//--- test/thcmd_assertions.sv
// thcmd_assertions: pin-level checks on the three-wire decoder.
// assumes the host keeps the serial clock idle high, 800 ns period.
`timescale 1ns/10ps
module thcmd_assertions (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  // three-wire pins
  input wire logic       ser_clk_in,
  input wire logic       ser_rst_in,
  input wire logic       dq_oe_out,
  // conversion side
  input wire logic       conv_start_out,
  input wire logic       conv_stop_out,
  input wire logic       conv_oneshot_out,
  input wire logic       conv_cpu_out,
  input wire logic [8:0] high_temp_limit_out,
  input wire logic [8:0] low_temp_limit_out
);
  default clocking dcb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_line_closed;
    !ser_rst_in [*5];
  endsequence
  sequence s_clk_high;
    ser_clk_in [*5];
  endsequence
  sequence s_opened;
    $past(ser_rst_in, 4);
  endsequence

  chk_line_release: assert property (
    s_line_closed |-> !dq_oe_out) else $error("data driven while closed");
  chk_clk_high_off: assert property (
    s_clk_high |-> !dq_oe_out) else $error("data driven in clock high");
  chk_launch_fall: assert property (
    $rose(dq_oe_out) |-> $past(ser_rst_in, 3) && !$past(ser_clk_in, 2))
    else $error("drive not launched on a fall");
  chk_start_pulse: assert property (
    conv_start_out |-> s_opened ##0 !conv_stop_out ##1 !conv_start_out)
    else $error("bad start pulse");
  chk_stop_pulse: assert property (
    conv_stop_out |-> s_opened ##1 !conv_stop_out)
    else $error("bad stop pulse");
  chk_high_hold: assert property (
    $changed(high_temp_limit_out) |-> s_opened)
    else $error("high limit changed outside a command");
  chk_low_hold: assert property (
    $changed(low_temp_limit_out) |-> s_opened)
    else $error("low limit changed outside a command");
  chk_mode_hold: assert property (
    $changed({conv_oneshot_out, conv_cpu_out}) |-> s_opened)
    else $error("mode changed outside a command");
endmodule : thcmd_assertions

//--- test/thcmd_host.sv
// thcmd_host: host model driving serial clock, line and data.
// assumes a pull-up on the data wire, resolved by the bench.
`timescale 1ns/10ps
module thcmd_host (
  // reference clock
  input  wire logic clk_in,
  // three-wire pins
  input  wire logic dq_in,
  output logic      ser_clk_out,
  output logic      ser_rst_out,
  output logic      dq_out,
  output logic      dq_oe_out
);
  initial begin
    ser_clk_out = 1'b1;
    ser_rst_out = 1'b0;
    dq_out      = 1'b0;
    dq_oe_out   = 1'b0;
  end

  task automatic xfer(input logic [7:0] op, input logic [8:0] wd,
                      input int n, input bit rd, output logic [8:0] rv);
    rv = '0;
    @(posedge clk_in);
    #1;
    ser_rst_out = 1'b1;
    #400;
    for (int i = 0; i < 8 + n; i++) begin
      ser_clk_out = 1'b0;
      dq_oe_out   = (i < 8) || !rd;
      dq_out      = (i < 8) ? op[i[2:0]] : wd[i - 8];
      #400;
      ser_clk_out = 1'b1;
      if (rd && i >= 8) rv[i - 8] = dq_in;
      #400;
    end
    dq_oe_out   = 1'b0;
    ser_rst_out = 1'b0;
    // wait out the nonvolatile busy time
    #2400;
  endtask : xfer
endmodule : thcmd_host

//--- test/thcmd_top_tb.sv
// thcmd_top_tb: self-checking bench for the three-wire decoder.
// assumes the host model thcmd_host and a pull-up on the data wire.
`timescale 1ns/10ps
module thcmd_top_tb;
  import thcmd_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic [8:0] wd;
    logic [3:0] n;
    logic       rd;
    logic [8:0] ex;
  } thcmd_row_t;
  localparam logic [8:0] TEMP = 9'h1A5;
  localparam logic [8:0] CNT  = 9'h0C3;
  localparam logic [8:0] SLP  = 9'h10F;
  logic       clk, rst, ser_clk, ser_rst, dq, d_dq, d_oe, h_dq, h_oe;
  logic       hflag, start_p, stop_p, oneshot, cpu;
  logic [8:0] hi_lim, lo_lim, rv;
  int         fails, checks, starts, stops;
  thcmd_row_t rows [13] = '{
    '{8'h01, 9'h050, 4'h9, 1'b0, 9'h000},
    '{8'hA1, 9'h000, 4'h9, 1'b1, 9'h050},
    '{8'h02, 9'h014, 4'h9, 1'b0, 9'h000},
    '{8'hA2, 9'h000, 4'h9, 1'b1, 9'h014},
    '{8'hAA, 9'h000, 4'h9, 1'b1, TEMP},
    '{8'hA0, 9'h000, 4'h9, 1'b1, CNT},
    '{8'hA9, 9'h000, 4'h9, 1'b1, SLP},
    '{8'h0C, 9'h003, 4'h8, 1'b0, 9'h000},
    '{8'hAC, 9'h000, 4'h8, 1'b1, 9'h08B},
    '{8'h0C, 9'h000, 4'h8, 1'b0, 9'h000},
    '{8'hAC, 9'h000, 4'h8, 1'b1, 9'h088},
    '{8'h55, 9'h000, 4'h9, 1'b1, 9'h1FF},
    '{8'hAA, 9'h000, 4'h3, 1'b1, TEMP & 9'h007}
  };

  assign dq = d_oe ? d_dq : (h_oe ? h_dq : 1'b1);

  thcmd_top #(.NV_CYCLES(20)) i_dut (
    .clk_in(clk), .rst_in(rst), .ser_clk_in(ser_clk),
    .ser_rst_in(ser_rst), .dq_in(dq), .dq_out(d_dq), .dq_oe_out(d_oe),
    .temp_in(TEMP), .count_in(CNT), .slope_in(SLP),
    .conv_done_in(1'b1), .high_flag_set_in(hflag),
    .low_flag_set_in(1'b0), .conv_start_out(start_p),
    .conv_stop_out(stop_p), .conv_oneshot_out(oneshot),
    .conv_cpu_out(cpu), .high_temp_limit_out(hi_lim),
    .low_temp_limit_out(lo_lim));
  thcmd_host i_host (.clk_in(clk), .dq_in(dq), .ser_clk_out(ser_clk),
    .ser_rst_out(ser_rst), .dq_out(h_dq), .dq_oe_out(h_oe));

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (start_p === 1'b1) starts++;
    if (stop_p === 1'b1) stops++;
  end

  initial begin
    #2_000_000;
    fails++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    hflag = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    foreach (rows[k]) begin
      i_host.xfer(rows[k].op, rows[k].wd, int'(rows[k].n), rows[k].rd, rv);
      if (rows[k].rd) check(rv, rows[k].ex);
    end
    check(hi_lim, 9'h050);
    check(lo_lim, 9'h014);
    i_host.xfer(8'h0C, 9'h003, 8, 1'b0, rv);
    check({7'h00, oneshot, cpu}, 9'h003);
    i_host.xfer(8'h0C, 9'h000, 8, 1'b0, rv);
    check({7'h00, oneshot, cpu}, 9'h000);
    check(9'(starts + stops), 9'h000);
    i_host.xfer(8'h22, 9'h000, 0, 1'b0, rv);
    i_host.xfer(8'hEE, 9'h000, 0, 1'b0, rv);
    i_host.xfer(8'hEE, 9'h000, 0, 1'b0, rv);
    check(9'(stops), 9'h001);
    check(9'(starts), 9'h002);
    @(posedge clk);
    #1;
    hflag = 1'b1;
    @(posedge clk);
    #1;
    hflag = 1'b0;
    i_host.xfer(8'hAC, 9'h000, 8, 1'b1, rv);
    check(rv, 9'h0C8);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(hi_lim, THCMD_HIGH_RST);
    i_host.xfer(8'hAC, 9'h000, 8, 1'b1, rv);
    check(rv, {1'b0, THCMD_CFG_RST});
    stop_test();
  end
endmodule : thcmd_top_tb

bind thcmd_top thcmd_assertions i_chk (
  .clk_in(clk_in), .rst_in(rst_in), .ser_clk_in(ser_clk_in),
  .ser_rst_in(ser_rst_in), .dq_oe_out(dq_oe_out),
  .conv_start_out(conv_start_out), .conv_stop_out(conv_stop_out),
  .conv_oneshot_out(conv_oneshot_out), .conv_cpu_out(conv_cpu_out),
  .high_temp_limit_out(high_temp_limit_out),
  .low_temp_limit_out(low_temp_limit_out));
